// ---- common/uob_pkg.sv ----
// constants, register map and carrier types for the otg pull and vbus boost
// block; assumes a 16-bit register port with read data one cycle later
package uob_pkg;

  // register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] IDX_USB_CTL   = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_OTG_CTL   = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_BOOST_PD  = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_BOOST_CTL = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_PWR_CTL   = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_STATUS    = 4'h5;

  // usb_control_reg fields
  localparam int USB_MODULE_ENABLE_BIT = 0;
  localparam int HOST_ROLE_ENABLE_BIT  = 3;
  localparam logic [DATA_W-1:0] USB_CTL_MASK = 16'h0009;

  // otg_control_reg fields
  localparam int VBUS_DISCHARGE_BIT     = 0;
  localparam int VBUS_TARGET_SELECT_BIT = 1;
  localparam int OTG_PULL_OVERRIDE_BIT  = 2;
  localparam int VBUS_GEN_ENABLE_BIT    = 3;
  localparam int DMINUS_PULLDOWN_BIT    = 4;
  localparam int DPLUS_PULLDOWN_BIT     = 5;
  localparam int DPLUS_PULLUP_BIT       = 7;
  localparam logic [DATA_W-1:0] OTG_CTL_MASK = 16'h00bf;

  // boost_period_duty_reg fields
  localparam int PERIOD_LSB = 0;
  localparam int DUTY_LSB   = 8;
  localparam int PWM_W      = 8;

  // boost_control_reg fields
  localparam int BOOST_COUNTER_ENABLE_BIT  = 8;
  localparam int BOOST_OUTPUT_POLARITY_BIT = 9;
  localparam int BOOST_OUTPUT_ENABLE_BIT   = 15;
  localparam logic [DATA_W-1:0] BOOST_CTL_MASK = 16'h8300;

  // usb_power_control_reg fields
  localparam int USB_POWER_ON_BIT = 0;
  localparam logic [DATA_W-1:0] PWR_CTL_MASK = 16'h0001;

  // status register fields (read only)
  localparam int ST_PWM_ACTIVE_BIT = 0;
  localparam int ST_ABOVE_TGT_BIT  = 1;
  localparam int ST_OVER_CUR_BIT   = 2;
  localparam int ST_DP_PULLUP_BIT  = 3;
  localparam int ST_DP_PULLDN_BIT  = 4;
  localparam int ST_DM_PULLDN_BIT  = 5;
  localparam int ST_BOOST_ON_BIT   = 6;
  localparam int ST_COUNT_LSB      = 8;

  // reset values
  localparam logic [DATA_W-1:0] REG_RST   = 16'h0000;
  localparam logic [PWM_W-1:0]  COUNT_RST = 8'h00;

  // register port request from software
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } uob_bus_req_t;

  // pad-side controls toward the transceiver and the boost stage
  typedef struct packed {
    logic dplus_pullup_en;
    logic dplus_pulldown_en;
    logic dminus_pulldown_en;
    logic boost_drive;
    logic vbus_gen_en;
    logic vbus_target_sel;
    logic vbus_discharge_en;
    logic usb_power_on;
  } uob_pad_t;

endpackage : uob_pkg

// ---- logic/uob_ctl.sv ----
// otg pull resistor control and vbus boost pwm with its register file
// assumes a plain register port on mclk and asynchronous comparator pins
`timescale 1ns/100ps
`default_nettype none

module uob_ctl (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire uob_pkg::uob_bus_req_t     bus_req,
  output var  logic [uob_pkg::DATA_W-1:0] rdata,
  input  wire logic                      vbus_above_lo_pin,
  input  wire logic                      vbus_above_hi_pin,
  input  wire logic                      over_current_pin,
  output var  uob_pkg::uob_pad_t         pad
);

  import uob_pkg::*;

  // address match shared by every register decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] idx);
    hit = (a == idx);
  endfunction : hit

  logic [DATA_W-1:0] usb_ctl_r;
  logic [DATA_W-1:0] otg_ctl_r;
  logic [DATA_W-1:0] boost_pd_r;
  logic [DATA_W-1:0] boost_ctl_r;
  logic [DATA_W-1:0] pwr_ctl_r;
  logic [DATA_W-1:0] rdata_r;
  logic [PWM_W-1:0]  count_r;
  logic [PWM_W-1:0]  count_nxt;
  uob_pad_t          pad_r;
  uob_pad_t          pad_nxt;

  logic above_lo_s;
  logic above_hi_s;
  logic over_cur_s;

  // comparator inputs cross into mclk through filtered synchronisers
  uob_sync3 u_sync_lo (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (vbus_above_lo_pin),
    .sync_out (above_lo_s)
  );

  uob_sync3 u_sync_hi (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (vbus_above_hi_pin),
    .sync_out (above_hi_s)
  );

  uob_sync3 u_sync_oc (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (over_current_pin),
    .sync_out (over_cur_s)
  );

  // write strobes per register
  wire wr_usb   = bus_req.wr && hit(bus_req.addr, IDX_USB_CTL);
  wire wr_otg   = bus_req.wr && hit(bus_req.addr, IDX_OTG_CTL);
  wire wr_pd    = bus_req.wr && hit(bus_req.addr, IDX_BOOST_PD);
  wire wr_bctl  = bus_req.wr && hit(bus_req.addr, IDX_BOOST_CTL);
  wire wr_pwr   = bus_req.wr && hit(bus_req.addr, IDX_PWR_CTL);

  // control fields
  wire module_en   = usb_ctl_r[USB_MODULE_ENABLE_BIT];
  wire host_en     = usb_ctl_r[HOST_ROLE_ENABLE_BIT];
  wire override_en = otg_ctl_r[OTG_PULL_OVERRIDE_BIT];
  wire dp_pu_ctl   = otg_ctl_r[DPLUS_PULLUP_BIT];
  wire dp_pd_ctl   = otg_ctl_r[DPLUS_PULLDOWN_BIT];
  wire dm_pd_ctl   = otg_ctl_r[DMINUS_PULLDOWN_BIT];
  wire gen_en      = otg_ctl_r[VBUS_GEN_ENABLE_BIT];
  wire tgt_sel     = otg_ctl_r[VBUS_TARGET_SELECT_BIT];
  wire discharge   = otg_ctl_r[VBUS_DISCHARGE_BIT];
  wire cnt_en      = boost_ctl_r[BOOST_COUNTER_ENABLE_BIT];
  wire pol         = boost_ctl_r[BOOST_OUTPUT_POLARITY_BIT];
  wire pwm_en      = boost_ctl_r[BOOST_OUTPUT_ENABLE_BIT];
  wire pwr_on      = pwr_ctl_r[USB_POWER_ON_BIT];

  wire [PWM_W-1:0] period = boost_pd_r[PERIOD_LSB +: PWM_W];
  wire [PWM_W-1:0] duty   = boost_pd_r[DUTY_LSB +: PWM_W];

  // software-visible registers; unmapped writes are dropped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      usb_ctl_r   <= REG_RST;
      otg_ctl_r   <= REG_RST;
      boost_pd_r  <= REG_RST;
      boost_ctl_r <= REG_RST;
      pwr_ctl_r   <= REG_RST;
    end else begin
      if (wr_usb)  usb_ctl_r   <= bus_req.wdata & USB_CTL_MASK;
      if (wr_otg)  otg_ctl_r   <= bus_req.wdata & OTG_CTL_MASK;
      if (wr_pd)   boost_pd_r  <= bus_req.wdata;
      if (wr_bctl) boost_ctl_r <= bus_req.wdata & BOOST_CTL_MASK;
      if (wr_pwr)  pwr_ctl_r   <= bus_req.wdata & PWR_CTL_MASK;
    end
  end

  // pwm counter: holds while disabled, wraps after reaching the period
  assign count_nxt = !cnt_en         ? count_r :
                     (count_r >= period) ? COUNT_RST :
                     count_r + 8'h01;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_r <= COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // raw pwm phase, then limits from the selected comparator
  wire pwm_phase = pwm_en && (count_r < duty);
  wire above_tgt = tgt_sel ? above_hi_s : above_lo_s;
  wire boost_on  = gen_en && pwm_phase &&
                   !above_tgt && !over_cur_s;
  // inactive level equals the polarity bit; active level its inverse
  wire boost_lvl = boost_on ^ pol;

  // pull resistors; suspend has no input here so it cannot drop them
  wire dp_pu = override_en ? dp_pu_ctl : module_en;
  wire dp_pd = override_en ? dp_pd_ctl : host_en;
  wire dm_pd = override_en ? dm_pd_ctl : host_en;

  // next pad state collected into the carrier
  always_comb begin
    pad_nxt                    = '0;
    pad_nxt.dplus_pullup_en    = dp_pu;
    pad_nxt.dplus_pulldown_en  = dp_pd;
    pad_nxt.dminus_pulldown_en = dm_pd;
    pad_nxt.boost_drive        = boost_lvl;
    pad_nxt.vbus_gen_en        = gen_en;
    pad_nxt.vbus_target_sel    = tgt_sel;
    pad_nxt.vbus_discharge_en  = discharge;
    pad_nxt.usb_power_on       = pwr_on;
  end

  // pad outputs come straight from flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pad_r <= '0;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  // status word showing the block's own live state
  wire [DATA_W-1:0] status_word = {count_r, 1'b0, pad_r.boost_drive ^ pol,
                                   dm_pd, dp_pd, dp_pu, over_cur_s,
                                   above_tgt, pwm_phase};

  // read mux; unmapped indices read zero
  wire [DATA_W-1:0] rd_mux =
    hit(bus_req.addr, IDX_USB_CTL)   ? usb_ctl_r   :
    hit(bus_req.addr, IDX_OTG_CTL)   ? otg_ctl_r   :
    hit(bus_req.addr, IDX_BOOST_PD)  ? boost_pd_r  :
    hit(bus_req.addr, IDX_BOOST_CTL) ? boost_ctl_r :
    hit(bus_req.addr, IDX_PWR_CTL)   ? pwr_ctl_r   :
    hit(bus_req.addr, IDX_STATUS)    ? status_word : REG_RST;

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= REG_RST;
    end else begin
      rdata_r <= bus_req.rd ? rd_mux : REG_RST;
    end
  end

  assign rdata = rdata_r;
  assign pad   = pad_r;

endmodule : uob_ctl

`default_nettype wire

// ---- logic/uob_sync3.sv ----
// three-stage synchroniser with agreement filter for one analog comparator
// assumes the input is asynchronous to mclk and changes slowly
`timescale 1ns/100ps
`default_nettype none

module uob_sync3 (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_r;
  logic s2_r;
  logic s3_r;
  logic out_r;

  // chain of three flops; stage one is read only by stage two
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
    end else begin
      meta_r <= async_in;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
    end
  end

  // output changes once the second and third stage agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      out_r <= s3_r;
    end
  end

  assign sync_out = out_r;

endmodule : uob_sync3

`default_nettype wire

// ---- test/tb_uob_ctl.sv ----
// self-checking bench for uob_ctl with a boost stage model
// assumes a 50 MHz mclk and the register port of the package
`timescale 1ns/100ps
`default_nettype none
module tb_uob_ctl;
  import uob_pkg::*;
  localparam logic [DATA_W-1:0] MSK [6] = '{USB_CTL_MASK, OTG_CTL_MASK,
    16'hffff, BOOST_CTL_MASK, PWR_CTL_MASK, 16'h0000};
  localparam logic [7:0] DL [4] = '{8'h00, 8'h03, 8'h08, 8'h03};
  localparam int EX [4] = '{0, 30, 80, 0}; // duty of 8 states, or none
  logic              mclk = 0, nrst = 0, oc = 0, pol = 0, rd_q = 0;
  logic              lo, hi, ocp;
  uob_bus_req_t      bus_req = '0;
  uob_pad_t          pad;
  logic [DATA_W-1:0] rdata, u, o, e;
  logic [DATA_W-1:0] exq [$];
  int                mismatches = 0, n_checks = 0, cyc = 0, n;
  int                seed = 32'h0e04;
  always #10 mclk = ~mclk;
  uob_ctl uut (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
    .vbus_above_lo_pin(lo), .vbus_above_hi_pin(hi),
    .over_current_pin(ocp), .pad(pad));
  uob_boost_model bm (.mclk(mclk), .pol(pol), .oc_cmd(oc), .pad(pad),
    .lo_pin(lo), .hi_pin(hi), .oc_pin(ocp));
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] ex);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, got, ex);
    end
  endtask : chk
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
    @(posedge mclk) bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    exq.push_back(ex);
  endtask : rd
  task idle(input int k);
    repeat (k) @(posedge mclk) bus_req <= '0;
  endtask : idle
  // count cycles with the boost switch at its active level
  // the bus is released on the first edge so a pending strobe lasts one cycle
  task meas(output int c);
    c = 0;
    repeat (80) begin
      @(posedge mclk);
      bus_req <= '0;
      if (pad.boost_drive === ~pol) c++;
    end
  endtask : meas
  // read data monitor and run-time ceiling
  always @(posedge mclk) begin
    rd_q <= bus_req.rd;
    cyc <= cyc + 1;
    if (rd_q) chk(rdata, exq.pop_front());
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    for (int a = 0; a < 10; a++) rd(a[3:0], REG_RST);
    // pull table, override alternating
    for (int i = 0; i < 8; i++) begin
      u = $random(seed);
      o = $random(seed);
      o[2] = i[0];
      e = '0;
      e[3] = o[2] ? o[7] : u[0];
      e[4] = o[2] ? o[5] : u[3];
      e[5] = o[2] ? o[4] : u[3];
      wr(IDX_USB_CTL, u);
      wr(IDX_OTG_CTL, o);
      rd(IDX_STATUS, e);
    end
    // counter disabled: count holds at zero, phase stays on
    oc <= 1'b1;
    wr(IDX_USB_CTL, 16'h0000);
    wr(IDX_PWR_CTL, 16'h0001);
    wr(IDX_BOOST_PD, 16'h0307);
    wr(IDX_BOOST_CTL, 16'h8000);
    wr(IDX_OTG_CTL, 16'h0008);
    idle(8);
    rd(IDX_STATUS, 16'h0005);
    meas(n);
    chk(n[15:0], 16'h0000);
    oc <= 1'b0;
    idle(10);
    meas(n);
    chk(n[15:0], 16'h0050);
    wr(IDX_BOOST_CTL, 16'h0000);
    idle(100);
    // enable order with power on and discharge off
    wr(IDX_OTG_CTL, 16'h0000);
    wr(IDX_BOOST_PD, 16'h0307);
    wr(IDX_BOOST_CTL, 16'h0200);
    pol <= 1'b1;
    wr(IDX_OTG_CTL, 16'h0002);
    wr(IDX_BOOST_CTL, 16'h0300);
    wr(IDX_BOOST_CTL, 16'h8300);
    wr(IDX_OTG_CTL, 16'h000a);
    for (int i = 0; i < 4; i++) begin
      oc <= (i == 3);
      wr(IDX_BOOST_PD, {DL[i], 8'h07});
      idle(10);
      meas(n);
      chk(n[15:0], EX[i][15:0]);
    end
    // low target: the comparator stops the switch once vbus passes it
    oc <= 1'b0;
    wr(IDX_BOOST_PD, 16'h0807);
    wr(IDX_OTG_CTL, 16'h0008);
    idle(200);
    meas(n);
    chk({15'h0000, n < 80}, 16'h0001);
    // high target: the same vbus level is still below it, switch runs on
    wr(IDX_OTG_CTL, 16'h000a);
    idle(10);
    meas(n);
    chk(n[15:0], 16'h0050);
    // back to back write and read, unmapped last
    for (int i = 0; i < 6; i++) begin
      u = $random(seed);
      wr(i < 5 ? i[3:0] : 4'h9, u);
      rd(i < 5 ? i[3:0] : 4'h9, u & MSK[i]);
    end
    idle(3);
    end_sim();
  end
endmodule : tb_uob_ctl
`default_nettype wire

// ---- test/uob_boost_model.sv ----
// behavioural boost stage: drive raises a vbus level, comparators report it
// assumes the active drive level is the inverse of the polarity bit
`timescale 1ns/100ps
`default_nettype none
module uob_boost_model #(
  parameter int TH_LO = 120,
  parameter int TH_HI = 240
) (
  input  wire logic              mclk,
  input  wire logic              pol,
  input  wire logic              oc_cmd,
  input  wire uob_pkg::uob_pad_t pad,
  output var  logic              lo_pin,
  output var  logic              hi_pin,
  output var  logic              oc_pin
);
  import uob_pkg::*;
  int lvl = 0;
  // vbus climbs while the switch is on and sags otherwise
  always @(posedge mclk) begin
    if (pad.boost_drive === ~pol) lvl <= lvl + 1;
    else if (lvl > 0) lvl <= lvl - 1;
  end
  // comparators and the commanded current limit
  assign lo_pin = lvl >= TH_LO;
  assign hi_pin = lvl >= TH_HI;
  assign oc_pin = oc_cmd;
endmodule : uob_boost_model
`default_nettype wire

// ---- test/uob_ctl_checker.sv ----
// concurrent checks on the pad and read data ports of uob_ctl
// assumes binding to uob_ctl and a shadow of the register writes
`timescale 1ns/100ps
`default_nettype none
module uob_ctl_checker (
  input wire logic                       mclk,
  input wire logic                       nrst,
  input wire uob_pkg::uob_bus_req_t      bus_req,
  input wire logic [uob_pkg::DATA_W-1:0] rdata,
  input wire uob_pkg::uob_pad_t          pad
);
  import uob_pkg::*;
  logic [DATA_W-1:0] u_r, o_r, b_r, p_r;
  logic              pu, pd, md, idle;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // shadow of the control registers, updated on writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      u_r <= REG_RST;
      o_r <= REG_RST;
      b_r <= REG_RST;
      p_r <= REG_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == IDX_USB_CTL) u_r <= bus_req.wdata;
      if (bus_req.addr == IDX_OTG_CTL) o_r <= bus_req.wdata;
      if (bus_req.addr == IDX_BOOST_CTL) b_r <= bus_req.wdata;
      if (bus_req.addr == IDX_PWR_CTL) p_r <= bus_req.wdata;
    end
  end
  // expected pull selection and idle boost stage
  assign pu = o_r[2] ? o_r[7] : u_r[0];
  assign pd = o_r[2] ? o_r[5] : u_r[3];
  assign md = o_r[2] ? o_r[4] : u_r[3];
  assign idle = !(b_r[15] && o_r[3]);
  a_pullup_sel: assert property (pad.dplus_pullup_en == $past(pu))
    else $error("pull-up selection wrong");
  a_dp_pulldown: assert property (pad.dplus_pulldown_en == $past(pd))
    else $error("d+ pull-down wrong");
  a_dm_pulldown: assert property (pad.dminus_pulldown_en == $past(md))
    else $error("d- pull-down wrong");
  a_target_sel: assert property (pad.vbus_target_sel == $past(o_r[1]))
    else $error("target select wrong");
  a_gen_enable: assert property (pad.vbus_gen_en == $past(o_r[3]))
    else $error("generation enable wrong");
  a_drive_idle: assert property ($past(idle) && $past(idle, 2) &&
    $past(b_r[9]) == $past(b_r[9], 2) |-> pad.boost_drive == $past(b_r[9]))
    else $error("boost drive not idle");
  a_power_flags: assert property ({pad.usb_power_on, pad.vbus_discharge_en}
    == $past({p_r[0], o_r[0]}))
    else $error("power flags wrong");
  a_pullup_hold: assert property (!$past(bus_req.wr) && !$past(bus_req.wr, 2)
    |-> $stable(pad.dplus_pullup_en))
    else $error("pull-up moved without a write");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == '0)
    else $error("read data outside read slot");
endmodule : uob_ctl_checker
bind uob_ctl uob_ctl_checker chk (.mclk(mclk), .nrst(nrst),
  .bus_req(bus_req), .rdata(rdata), .pad(pad));
`default_nettype wire
